// File: src/ptp_period_timer_pwm.sv
// Period timer with prescaler, postscaler and a double-buffered 10-bit PWM, behind an AXI4-Lite slave.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ptp_period_timer_pwm
    import ptp_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output var  logic              wave_output_pin_o,
    output var  logic              wave_output_pin_oe
);

    // Maps a byte address to a register index and tells whether it is mapped.
    function automatic logic [REG_IDX_W:0] decode(input logic [ADDR_W-1:0] addr);
        logic [REG_IDX_W-1:0] idx;
        logic                 hit;
        idx = addr[REG_IDX_W+1:2];
        hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:REG_IDX_W+2] == '0);
        unique case (idx)
            IDX_INT_CTRL, IDX_PERIPH_FLAGS, IDX_PERIOD_CNT, IDX_TICK_CTRL,
            IDX_DUTY_BUF, IDX_ACTIVE_DUTY, IDX_CMP_CTRL, IDX_PIN_DATA,
            IDX_PIN_DIR, IDX_PERIPH_EN, IDX_PERIOD_LIM: hit = hit;
            default: hit = 1'b0;
        endcase
        return {hit, idx};
    endfunction : decode

    // Software-visible registers; active_duty_ext is internal and cannot be read or written.
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_flags;
    logic [7:0] peripheral_enables;
    logic [7:0] period_counter;
    logic [7:0] tick_timer_control;
    logic [7:0] period_limit;
    logic [7:0] duty_buffer;
    logic [7:0] active_duty;
    logic [1:0] active_duty_ext;
    logic [7:0] compare_unit_control;
    logic [7:0] wave_pin_direction;
    logic [7:0] wave_pin_data_latch;

    // Time base state.
    logic [1:0] phase;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic       pwm_latch;

    // Bus write side.
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [7:0]        w_byte;
    logic              w_lane0;
    logic              w_held;

    logic [REG_IDX_W:0]   wdec;
    logic [REG_IDX_W:0]   rdec;
    logic                 wr_go;
    logic                 wr_ok;
    logic [REG_IDX_W-1:0] wr_idx;

    assign wdec   = decode(aw_addr);
    assign rdec   = decode(s_axi_araddr);
    assign wr_go  = aw_held && w_held && !s_axi_bvalid;
    assign wr_ok  = wr_go && wdec[REG_IDX_W] && w_lane0;
    assign wr_idx = wdec[REG_IDX_W-1:0];

    logic wr_cnt;
    logic wr_tc;
    assign wr_cnt = wr_ok && (wr_idx == IDX_PERIOD_CNT);
    assign wr_tc  = wr_ok && (wr_idx == IDX_TICK_CTRL);

    // Time base decode.
    logic       run;
    logic [1:0] pre_sel;
    logic [3:0] pre_end;
    logic       tick;
    logic       rollover;
    logic       pwm_mode;
    logic [1:0] low_bits;

    assign run      = tick_timer_control[TC_RUN_BIT];
    assign pre_sel  = tick_timer_control[TC_PRE_LO +: 2];
    assign pwm_mode = compare_unit_control[CC_MODE_LO +: 2] == CC_MODE_PWM;

    always_comb begin
        unique case (pre_sel)
            2'h0: begin
                pre_end  = PRE_END_1;
                low_bits = phase;
            end
            2'h1: begin
                pre_end  = PRE_END_4;
                low_bits = pre_cnt[1:0];
            end
            default: begin
                pre_end  = PRE_END_16;
                low_bits = pre_cnt[3:2];
            end
        endcase
    end

    assign tick     = run && (phase == PHASE_LAST) && (pre_cnt == pre_end);
    assign rollover = tick && (period_counter == period_limit);

    // Write address and data channels are taken independently.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            w_byte  <= RST_ZERO;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wdec[REG_IDX_W] ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel: one cycle from address to data.
    logic [7:0] rd_byte;
    always_comb begin
        unique case (rdec[REG_IDX_W-1:0])
            IDX_INT_CTRL:     rd_byte = interrupt_control;
            IDX_PERIPH_FLAGS: rd_byte = peripheral_flags;
            IDX_PERIOD_CNT:   rd_byte = period_counter;
            IDX_TICK_CTRL:    rd_byte = tick_timer_control;
            IDX_DUTY_BUF:     rd_byte = duty_buffer;
            IDX_ACTIVE_DUTY:  rd_byte = active_duty;
            IDX_CMP_CTRL:     rd_byte = compare_unit_control;
            IDX_PIN_DATA:     rd_byte = wave_pin_data_latch;
            IDX_PIN_DIR:      rd_byte = wave_pin_direction;
            IDX_PERIPH_EN:    rd_byte = peripheral_enables;
            IDX_PERIOD_LIM:   rd_byte = period_limit;
            default:          rd_byte = RST_ZERO;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdec[REG_IDX_W] ? rd_byte : RST_ZERO};
            s_axi_rresp  <= rdec[REG_IDX_W] ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Plain storage registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_control    <= RST_ZERO;
            peripheral_enables   <= RST_ZERO;
            period_limit         <= RST_PERIOD_LIM;
            duty_buffer          <= RST_ZERO;
            compare_unit_control <= RST_ZERO;
            wave_pin_data_latch  <= RST_ZERO;
            wave_pin_direction   <= RST_PIN_DIR;
        end else if (wr_ok) begin
            unique case (wr_idx)
                IDX_INT_CTRL:   interrupt_control    <= w_byte;
                IDX_PERIPH_EN:  peripheral_enables   <= w_byte;
                IDX_PERIOD_LIM: period_limit         <= w_byte;
                IDX_DUTY_BUF:   duty_buffer          <= w_byte;
                IDX_CMP_CTRL:   compare_unit_control <= w_byte;
                IDX_PIN_DATA:   wave_pin_data_latch  <= w_byte;
                IDX_PIN_DIR:    wave_pin_direction   <= w_byte;
                default:        interrupt_control    <= interrupt_control;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_timer_control <= RST_ZERO;
        end else if (wr_tc) begin
            tick_timer_control <= w_byte & TICK_CTRL_MASK;
        end
    end

    // Period counter: a control write leaves it alone.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_counter <= RST_ZERO;
        end else if (wr_cnt) begin
            period_counter <= w_byte;
        end else if (rollover) begin
            period_counter <= RST_ZERO;
        end else if (tick) begin
            period_counter <= period_counter + 8'h01;
        end
    end

    // Quarter phase and prescaler.
    always_ff @(posedge aclk) begin
        if (!aresetn || wr_cnt || wr_tc) begin
            phase   <= 2'h0;
            pre_cnt <= 4'h0;
        end else if (run) begin
            phase <= phase + 2'h1;
            if (phase == PHASE_LAST) begin
                pre_cnt <= (pre_cnt == pre_end) ? 4'h0 : pre_cnt + 4'h1;
            end
        end
    end

    // Postscaler counts period matches only; the PWM never sees it.
    always_ff @(posedge aclk) begin
        if (!aresetn || wr_cnt || wr_tc) begin
            post_cnt <= 4'h0;
        end else if (rollover) begin
            if (post_cnt == tick_timer_control[TC_POST_LO +: 4]) begin
                post_cnt <= 4'h0;
            end else begin
                post_cnt <= post_cnt + 4'h1;
            end
        end
    end

    // Flag register: a hardware set wins over a software clear.
    logic post_done;
    assign post_done = rollover && (post_cnt == tick_timer_control[TC_POST_LO +: 4]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peripheral_flags <= RST_ZERO;
        end else begin
            if (wr_ok && wr_idx == IDX_PERIPH_FLAGS) begin
                peripheral_flags <= w_byte;
            end
            if (post_done) begin
                peripheral_flags[FLAG_MATCH_BIT] <= 1'b1;
            end
        end
    end

    // Active duty is loaded at rollover; software may write it only outside PWM mode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_duty     <= RST_ZERO;
            active_duty_ext <= 2'h0;
        end else if (rollover) begin
            active_duty     <= duty_buffer;
            active_duty_ext <= compare_unit_control[CC_DUTY_LO +: 2];
        end else if (wr_ok && wr_idx == IDX_ACTIVE_DUTY && !pwm_mode) begin
            active_duty <= w_byte;
        end
    end

    // PWM latch: set at rollover unless the new duty is zero, cleared on a duty match.
    logic duty_zero;
    logic duty_match;
    assign duty_zero  = {duty_buffer, compare_unit_control[CC_DUTY_LO +: 2]} == 10'h000;
    assign duty_match = {active_duty, active_duty_ext} == {period_counter, low_bits};

    always_ff @(posedge aclk) begin
        if (!aresetn || compare_unit_control == RST_ZERO) begin
            pwm_latch <= 1'b0;
        end else if (pwm_mode && rollover) begin
            pwm_latch <= !duty_zero;
        end else if (pwm_mode && duty_match) begin
            pwm_latch <= 1'b0;
        end
    end

    // Pin drive: waveform in PWM mode, port data latch otherwise.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_output_pin_o  <= 1'b0;
            wave_output_pin_oe <= 1'b0;
        end else begin
            // Masking with the match drops the pin in the first matching cycle, so high time is duty exactly.
            wave_output_pin_o  <= pwm_mode ? (pwm_latch && !duty_match) : wave_pin_data_latch[PIN_BIT];
            wave_output_pin_oe <= !wave_pin_direction[PIN_BIT];
        end
    end

endmodule : ptp_period_timer_pwm
`default_nettype wire

// File: src/ptp_pkg.sv
// Package with register indices, field positions and reset values of the period timer PWM block.
package ptp_pkg;

    localparam int          REG_IDX_W        = 8;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0]  IDX_INT_CTRL     = 8'h0b;
    localparam logic [7:0]  IDX_PERIPH_FLAGS = 8'h0c;
    localparam logic [7:0]  IDX_PERIOD_CNT   = 8'h11;
    localparam logic [7:0]  IDX_TICK_CTRL    = 8'h12;
    localparam logic [7:0]  IDX_DUTY_BUF     = 8'h15;
    localparam logic [7:0]  IDX_ACTIVE_DUTY  = 8'h16;
    localparam logic [7:0]  IDX_CMP_CTRL     = 8'h17;
    localparam logic [7:0]  IDX_PIN_DATA     = 8'h06;
    localparam logic [7:0]  IDX_PIN_DIR      = 8'h86;
    localparam logic [7:0]  IDX_PERIPH_EN    = 8'h8c;
    localparam logic [7:0]  IDX_PERIOD_LIM   = 8'h92;

    localparam logic [7:0]  RST_ZERO         = 8'h00;
    localparam logic [7:0]  RST_PERIOD_LIM   = 8'hff;
    localparam logic [7:0]  RST_PIN_DIR      = 8'hff;

    // Field positions.
    localparam int          TC_PRE_LO        = 0;
    localparam int          TC_RUN_BIT       = 2;
    localparam int          TC_POST_LO       = 3;
    localparam int          FLAG_MATCH_BIT   = 1;
    localparam int          CC_DUTY_LO       = 4;
    localparam int          CC_MODE_LO       = 2;
    localparam int          PIN_BIT          = 2;
    localparam logic [1:0]  CC_MODE_PWM      = 2'h3;
    localparam logic [7:0]  TICK_CTRL_MASK   = 8'h7f;

    // Prescaler terminal counts for 1:1, 1:4 and 1:16.
    localparam logic [3:0]  PRE_END_1        = 4'h0;
    localparam logic [3:0]  PRE_END_4        = 4'h3;
    localparam logic [3:0]  PRE_END_16       = 4'hf;
    localparam logic [1:0]  PHASE_LAST       = 2'h3;

    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage : ptp_pkg

// File: verif/ptp_props.sv
// Checker of pin timing and pin direction of the period timer PWM block.
`timescale 1ns/1ps
`default_nettype none
module ptp_props
    import ptp_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              wave_output_pin_o,
    input wire logic              wave_output_pin_oe
);
    logic [7:0] aw_i, wd, lim, db, cc, tc, dir;
    logic       bv_q, pin_q, wr, run, pwm, settled, rise, fell;
    int         age, gap, hi, pre, per, dty;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    assign wr      = s_axi_bvalid && !bv_q;
    assign pre     = (tc[1:0] == 2'h0) ? 1 : (tc[1:0] == 2'h1) ? 4 : 16;
    assign per     = (int'(lim) + 1) * 4 * pre;
    assign dty     = int'({db, cc[5:4]});
    assign run     = tc[TC_RUN_BIT];
    assign pwm     = cc[3:2] == CC_MODE_PWM;
    assign settled = run && pwm && age > 3 * per;
    assign rise    = wave_output_pin_o && !pin_q;
    assign fell    = !wave_output_pin_o && pin_q;
    // Shadow copies of the registers that shape the waveform, one cycle behind the block.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_i, wd, db, cc, tc} <= '0;
            lim  <= RST_PERIOD_LIM;
            dir  <= RST_PIN_DIR;
            bv_q <= 1'b0;
            age  <= 0;
        end else begin
            bv_q <= s_axi_bvalid;
            age  <= wr ? 0 : (age < 100000) ? age + 1 : age;
            if (s_axi_awvalid && s_axi_awready) aw_i <= s_axi_awaddr[9:2];
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
            if (wr && aw_i == IDX_PERIOD_LIM) lim <= wd;
            if (wr && aw_i == IDX_DUTY_BUF) db <= wd;
            if (wr && aw_i == IDX_CMP_CTRL) cc <= wd;
            if (wr && aw_i == IDX_TICK_CTRL) tc <= wd;
            if (wr && aw_i == IDX_PIN_DIR) dir <= wd;
        end
    end
    always_ff @(posedge aclk) begin
        pin_q <= wave_output_pin_o;
        gap   <= rise ? 1 : gap + 1;
        hi    <= wave_output_pin_o ? hi + 1 : 0;
    end
    a_oe_after_reset: assert property ($rose(aresetn) |-> !wave_output_pin_oe)
        else $error("pin driven right after reset");
    a_oe_follows_dir: assert property (age > 2 |-> wave_output_pin_oe == !dir[PIN_BIT])
        else $error("pin enable differs from direction bit");
    a_dir_to_oe: assert property (wr && aw_i == IDX_PIN_DIR |-> ##[0:1] wave_output_pin_oe == !wd[PIN_BIT])
        else $error("direction write not reflected on pin enable");
    a_period_gap: assert property (settled && rise |-> gap == per)
        else $error("pwm period wrong");
    a_high_time: assert property (settled && fell |-> hi == dty * pre)
        else $error("pwm high time wrong");
    a_zero_duty_low: assert property (settled && dty == 0 |-> !wave_output_pin_o)
        else $error("pin set with zero duty");
    a_full_duty_high: assert property (settled && dty >= (int'(lim) + 1) * 4 |-> wave_output_pin_o)
        else $error("pin cleared with duty beyond period");
    a_run_freeze: assert property (age > 4 && !run |-> $stable(wave_output_pin_o))
        else $error("pin moved while timer stopped");
    c_rise: cover property (settled && rise);
    c_fall: cover property (settled && fell);
    c_dir: cover property (wr && aw_i == IDX_PIN_DIR);
endmodule : ptp_props
bind ptp_period_timer_pwm ptp_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// File: verif/ptp_pin_load.sv
// Load on the wave output pin that measures period and high time.
`timescale 1ns/1ps
`default_nettype none
module ptp_pin_load (
    input  wire logic clk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output var  logic lvl,
    output var  int   period,
    output var  int   high,
    output var  int   rises
);
    logic flip = 1'b0;
    logic prev = 1'b0;
    int   cnt  = 0;
    int   hcnt = 0;
    // The pin has no pull, so a released pin shows a level that changes every cycle.
    assign lvl = pin_oe ? pin_o : flip;
    initial begin
        period = 0;
        high = 0;
        rises = 0;
    end
    always @(posedge clk) begin
        flip <= ~flip;
        prev <= lvl;
        cnt  <= cnt + 1;
        hcnt <= lvl ? hcnt + 1 : 0;
        if (pin_oe && lvl && !prev) begin
            period <= cnt;
            cnt    <= 1;
            rises  <= rises + 1;
        end
        if (pin_oe && !lvl && prev) high <= hcnt;
    end
endmodule : ptp_pin_load
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench of the period timer PWM block with a register model and a pin load.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ptp_pkg::*;
;
    logic        aclk, aresetn, awv, wv, bready, arv, rready, awr, wr_r, bv, arr, rv, pin_o, pin_oe, lvl;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    int          err_total, checks, cyc, ld_per, ld_hi, ld_rises;
    int          mdl [256];
    logic [7:0]  regs [$] = '{IDX_INT_CTRL, IDX_PERIPH_FLAGS, IDX_PERIOD_CNT, IDX_TICK_CTRL, IDX_DUTY_BUF,
                             IDX_ACTIVE_DUTY, IDX_CMP_CTRL, IDX_PIN_DATA, IDX_PIN_DIR, IDX_PERIPH_EN, IDX_PERIOD_LIM};
    ptp_period_timer_pwm #(.ADDR_W(12)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .wave_output_pin_o(pin_o),
        .wave_output_pin_oe(pin_oe));
    ptp_pin_load u_load (.clk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .lvl(lvl), .period(ld_per), .high(ld_hi),
        .rises(ld_rises));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata  <= {24'h00_0000, d};
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv);
        bready <= 1'b0;
        chk(bresp, (mdl[idx] < 0) ? RESP_SLVERR : RESP_OKAY);
        if (idx == IDX_TICK_CTRL) d &= TICK_CTRL_MASK;
        if (mdl[idx] >= 0 && !(idx == IDX_ACTIVE_DUTY && mdl[IDX_CMP_CTRL][3:2] == 2'h3)) mdl[idx] = d;
    endtask : wr
    task automatic rc(input logic [7:0] idx);
        @(posedge aclk);
        araddr <= {2'h0, idx, 2'h0};
        arv    <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rready <= 1'b0;
        chk(rresp, (mdl[idx] < 0) ? RESP_SLVERR : RESP_OKAY);
        chk(rdata, (mdl[idx] < 0) ? 0 : mdl[idx]);
    endtask : rc
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        int l, d, sel, p, per;
        {aresetn, awv, wv, bready, arv, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        foreach (mdl[i]) mdl[i] = -1;
        foreach (regs[i]) mdl[regs[i]] = 0;
        mdl[IDX_PERIOD_LIM] = RST_PERIOD_LIM;
        mdl[IDX_PIN_DIR] = RST_PIN_DIR;
        void'($urandom(32'hbec8));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i]) rc(regs[i]);
        rc(8'h00);
        wr(8'h00, 8'h5a);
        $display("test reset_values done");
        foreach (regs[i]) wr(regs[i], (8'($urandom) | 8'h80) & 8'hfb);
        foreach (regs[i]) rc(regs[i]);
        $display("test register_rw done");
        wr(IDX_PIN_DATA, 8'h00);
        wr(IDX_PIN_DIR, 8'hfb);
        for (sel = 0; sel < 3; sel++) begin
            p = (sel == 0) ? 1 : (sel == 1) ? 4 : 16;
            l = $urandom_range(6, 1);
            d = $urandom_range((l + 1) * 4 - 1, 1);
            per = (l + 1) * 4 * p;
            wr(IDX_TICK_CTRL, 8'h00);
            // A leftover count above the new limit would wrap through FFh first.
            wr(IDX_PERIOD_CNT, 8'h00);
            wr(IDX_PERIOD_LIM, 8'(l));
            wr(IDX_DUTY_BUF, 8'(d >> 2));
            wr(IDX_CMP_CTRL, 8'(8'h0c | (d % 4) << 4));
            wr(IDX_TICK_CTRL, 8'(sel | 4 | $urandom_range(15, 0) << 3));
            repeat (5 * per) @(posedge aclk);
            chk(ld_per, per);
            chk(ld_hi, d * p);
            mdl[IDX_ACTIVE_DUTY] = d >> 2;
            wr(IDX_ACTIVE_DUTY, 8'h3c);
            rc(IDX_ACTIVE_DUTY);
        end
        $display("test pwm_timing done");
        wr(IDX_DUTY_BUF, 8'h00);
        wr(IDX_CMP_CTRL, 8'h0c);
        repeat (2 * per) @(posedge aclk);
        l = ld_rises;
        repeat (2 * per) @(posedge aclk);
        chk(ld_rises - l, 0);
        chk(lvl, 1'b0);
        wr(IDX_DUTY_BUF, 8'hff);
        repeat (3 * per) @(posedge aclk);
        chk(lvl, 1'b1);
        repeat (per / 2) @(posedge aclk);
        chk(lvl, 1'b1);
        // With the timer stopped no rollover can set the latch again, so PWM mode shows the cleared latch.
        wr(IDX_TICK_CTRL, 8'h00);
        wr(IDX_CMP_CTRL, 8'h00);
        wr(IDX_CMP_CTRL, 8'h0c);
        repeat (3) @(posedge aclk);
        chk(pin_o, 1'b0);
        wr(IDX_PIN_DIR, 8'hff);
        repeat (3) @(posedge aclk);
        chk(pin_oe, 1'b0);
        $display("test pwm_edges done");
        wr(IDX_TICK_CTRL, 8'h00);
        wr(IDX_PERIOD_CNT, 8'h37);
        repeat (200) @(posedge aclk);
        rc(IDX_PERIOD_CNT);
        $display("test freeze done");
        wr(IDX_PERIOD_LIM, 8'h03);
        for (p = 0; p < 16; p += 5) begin
            wr(IDX_TICK_CTRL, 8'h00);
            wr(IDX_PERIOD_CNT, 8'h00);
            wr(IDX_PERIPH_FLAGS, 8'h00);
            wr(IDX_TICK_CTRL, 8'(4 | p << 3));
            repeat (p * 16 + 8) @(posedge aclk);
            rc(IDX_PERIPH_FLAGS);
            mdl[IDX_PERIPH_FLAGS] = 1 << FLAG_MATCH_BIT;
            repeat (16) @(posedge aclk);
            rc(IDX_PERIPH_FLAGS);
        end
        $display("test postscaler done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
